// >>> rtl/apm_level_decode.sv
// Classifies a power management level byte into its band.
// Pure combinational; the caller registers the results.
`timescale 1ns/1ps
module apm_level_decode (
   // Level in
   input  wire logic [7:0]               level_i,
   // Classification out
   output ata_cfg_pkg::apm_class_t       class_o,
   output logic                          valid_o,
   output logic                          standby_allowed_o
);
   import ata_cfg_pkg::*;

   wire is_reserved = (level_i == APM_RSV_LO) || (level_i == APM_RSV_HI);
   wire is_full     = (level_i == APM_MAX_PERF);
   wire no_standby  = (level_i >= APM_MIN_NOSTBY);

   assign valid_o           = !is_reserved;
   assign standby_allowed_o = !is_reserved && !no_standby;
   assign class_o = is_reserved ? APM_RESERVED :
                    is_full     ? APM_FULL_PERF :
                    no_standby  ? APM_NO_STANDBY : APM_WITH_STANDBY;

endmodule

// >>> rtl/ata_cfg_pkg.sv
// Constants, encodings and carrier types of the configuration command handler.
// Assumes the task-file bytes arrive already decoded on the controller clock.
package ata_cfg_pkg;

   // Command opcodes
   localparam logic [7:0] OP_SET_FEATURES = 8'hef;
   localparam logic [7:0] OP_SET_MAX      = 8'hf9;
   localparam logic [7:0] OP_SET_MULTIPLE = 8'hc6;

   // Set Features subcommands handled here
   localparam logic [7:0] FT_APM_ON    = 8'h05;
   localparam logic [7:0] FT_APM_OFF   = 8'h85;
   localparam logic [7:0] FT_PL1_ON    = 8'h0a;
   localparam logic [7:0] FT_PL1_OFF   = 8'h8a;
   localparam logic [7:0] FT_RLA_OFF   = 8'h55;
   localparam logic [7:0] FT_LONG_4B   = 8'hbb;
   localparam logic [7:0] FT_POR_OFF   = 8'h66;
   localparam logic [7:0] FT_POR_ON    = 8'hcc;
   localparam logic [7:0] FT_CUR_LIMIT = 8'h9a;

   // Set max address subfunctions
   localparam logic [7:0] SM_ADDRESS  = 8'h00;
   localparam logic [7:0] SM_PASSWORD = 8'h01;
   localparam logic [7:0] SM_LOCK     = 8'h02;
   localparam logic [7:0] SM_UNLOCK   = 8'h03;
   localparam logic [7:0] SM_FREEZE   = 8'h04;

   // Power management level bands
   localparam logic [7:0] APM_RSV_LO     = 8'h00;
   localparam logic [7:0] APM_MIN_STBY   = 8'h01;
   localparam logic [7:0] APM_MIN_NOSTBY = 8'h80;
   localparam logic [7:0] APM_MAX_PERF   = 8'hfe;
   localparam logic [7:0] APM_RSV_HI     = 8'hff;
   localparam logic [7:0] APM_LEVEL_DEF  = 8'hfe;

   // Field positions
   localparam int DH_LBA_BIT   = 6;
   localparam int DH_DEV_BIT   = 4;
   localparam int KEEP_BIT     = 0;

   // Current limit range in units of 4 mA, and block count limit
   localparam logic [7:0] CUR_LIMIT_MIN = 8'h19;
   localparam logic [7:0] CUR_LIMIT_MAX = 8'h7d;
   localparam logic [7:0] MULT_MAX      = 8'h10;
   localparam int         LBA_W         = 28;
   localparam logic [LBA_W-1:0] NATIVE_MAX_LBA = 28'h0ffffff;

   typedef enum logic [1:0] {
      APM_RESERVED,
      APM_WITH_STANDBY,
      APM_NO_STANDBY,
      APM_FULL_PERF
   } apm_class_t;

   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] features;
      logic [7:0] sect_cnt;
      logic [7:0] sect_num;
      logic [7:0] cyl_lo;
      logic [7:0] cyl_hi;
      logic [7:0] drv_head;
   } task_file_t;

   typedef struct packed {
      logic       abort;
      logic       ret_valid;
      logic [7:0] ret_lo;
      logic [7:0] ret_hi;
   } cmd_result_t;

endpackage

// >>> rtl/ata_config_command_handler.sv
// Configuration command handler: Set Features power subcommands, Set max
// address with its lock subfunctions, and Set Multiple Mode.
// Assumes task-file bytes and strobes come from logic on clk_sys_i.
`timescale 1ns/1ps
module ata_config_command_handler (
   // Clock and reset (power-on)
   input  wire logic                     clk_sys_i,
   input  wire logic                     reset_i,
   // Other resets, one-cycle pulses
   input  wire logic                     hw_reset_i,
   input  wire logic                     soft_reset_i,
   // Command request
   input  wire logic                     cmd_valid_i,
   input  wire ata_cfg_pkg::task_file_t  task_file_i,
   input  wire logic                     drive_select_bit_i,
   input  wire logic                     drive_ready_i,
   input  wire logic                     read_native_ok_i,
   // Command completion
   output logic                          busy_o,
   output logic                          done_irq_o,
   output ata_cfg_pkg::cmd_result_t      result_o,
   // Power settings
   output logic                          apm_enabled_o,
   output logic [7:0]                    apm_level_o,
   output logic                          standby_allowed_o,
   output logic                          pl1_enabled_o,
   output logic [7:0]                    current_limit_o,
   output logic                          por_on_soft_reset_o,
   // Maximum address state
   output logic [ata_cfg_pkg::LBA_W-1:0] max_lba_o,
   output logic [ata_cfg_pkg::LBA_W-1:0] kept_max_lba_o,
   output logic                          max_locked_o,
   output logic                          max_frozen_o,
   // Multiple mode
   output logic                          multiple_en_o,
   output logic [7:0]                    multiple_count_o
);
   import ata_cfg_pkg::*;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i || hw_reset_i || soft_reset_i);

   typedef enum logic {ST_IDLE, ST_EXEC} state_t;

   state_t            state_r;
   task_file_t        tf_r;
   logic              busy_r;
   logic              irq_r;
   cmd_result_t       res_r;
   logic              apm_en_r;
   logic [7:0]        apm_level_r;
   logic              stby_ok_r;
   logic              pl1_en_r;
   logic [7:0]        cur_limit_r;
   logic              por_soft_r;
   logic [LBA_W-1:0]  max_lba_r;
   logic [LBA_W-1:0]  kept_lba_r;
   logic              locked_r;
   logic              frozen_r;
   logic              kept_done_r;
   logic              prev_native_r;
   logic              mult_en_r;
   logic [7:0]        mult_cnt_r;

   // Reset events; the power-on reset also clears the maximum-address state
   wire any_reset   = hw_reset_i || soft_reset_i;
   wire restore_def = hw_reset_i || (soft_reset_i && por_soft_r);

   wire addressed = (task_file_i.drv_head[DH_DEV_BIT] == drive_select_bit_i);
   wire take      = (state_r == ST_IDLE) && cmd_valid_i && addressed && !any_reset;
   wire exec      = (state_r == ST_EXEC) && !any_reset;

   wire [7:0] feat = tf_r.features;
   wire [7:0] cnt  = tf_r.sect_cnt;
   wire is_sf   = (tf_r.cmd == OP_SET_FEATURES);
   wire is_max  = (tf_r.cmd == OP_SET_MAX);
   wire is_mult = (tf_r.cmd == OP_SET_MULTIPLE);

   // Level and block count checks; the band class itself is not needed here
   logic       apm_valid;
   logic       apm_stby;
   logic       blk_zero;
   logic       blk_ok;

   apm_level_decode u_apm (
      .level_i           (cnt),
      .class_o           (),
      .valid_o           (apm_valid),
      .standby_allowed_o (apm_stby)
   );

   block_count_check u_blk (
      .count_i     (cnt),
      .zero_o      (blk_zero),
      .supported_o (blk_ok)
   );

   // Set Features decode; 55h/BBh are accepted as no-ops, other codes abort
   wire f_apm_on  = is_sf && (feat == FT_APM_ON);
   wire f_apm_off = is_sf && (feat == FT_APM_OFF);
   wire f_pl1_on  = is_sf && (feat == FT_PL1_ON);
   wire f_pl1_off = is_sf && (feat == FT_PL1_OFF);
   wire f_nop     = is_sf && ((feat == FT_RLA_OFF) || (feat == FT_LONG_4B));
   wire f_por_off = is_sf && (feat == FT_POR_OFF);
   wire f_por_on  = is_sf && (feat == FT_POR_ON);
   wire f_cur     = is_sf && (feat == FT_CUR_LIMIT);
   wire sf_known  = f_apm_on || f_apm_off || f_pl1_on || f_pl1_off || f_nop ||
                    f_por_off || f_por_on || f_cur;
   wire sf_abort  = is_sf && (!sf_known || (f_apm_on && !apm_valid));

   // Current limit clamp to the supported window
   wire [7:0] cur_next = (cnt < CUR_LIMIT_MIN) ? CUR_LIMIT_MIN :
                         (cnt > CUR_LIMIT_MAX) ? CUR_LIMIT_MAX : cnt;

   // Set max address decode
   wire [LBA_W-1:0] new_lba = {tf_r.drv_head[3:0], tf_r.cyl_hi, tf_r.cyl_lo,
                               tf_r.sect_num};
   wire keep_across_reset_flag = cnt[KEEP_BIT];
   wire m_addr  = is_max && (feat == SM_ADDRESS);
   wire m_pw    = is_max && (feat == SM_PASSWORD);
   wire m_lock  = is_max && (feat == SM_LOCK);
   wire m_ulock = is_max && (feat == SM_UNLOCK);
   wire m_frz   = is_max && (feat == SM_FREEZE);
   wire m_rsvd  = is_max && (feat > SM_FREEZE);
   wire addr_bad = !drive_ready_i || !prev_native_r ||
                   !tf_r.drv_head[DH_LBA_BIT];
   wire addr_abort = m_addr && (addr_bad || locked_r || frozen_r ||
                     (keep_across_reset_flag && kept_done_r));
   wire sub_abort  = (m_pw || m_lock || m_ulock) && frozen_r;
   wire max_abort  = addr_abort || sub_abort || m_rsvd;
   wire addr_go    = m_addr && !addr_abort;

   // Set multiple decode
   wire mult_abort = is_mult && !blk_zero && !blk_ok;

   // No power-level gate exists: level 0 never refuses a command
   wire cmd_abort = sf_abort || max_abort || mult_abort ||
                    !(is_sf || is_max || is_mult);

   // Sequencer: one busy cycle, then completion
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || any_reset) begin
         state_r <= ST_IDLE;
         busy_r  <= 1'b0;
      end else if (take) begin
         state_r <= ST_EXEC;
         busy_r  <= 1'b1;
      end else if (exec) begin
         state_r <= ST_IDLE;
         busy_r  <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         tf_r <= '0;
      end else if (take) begin
         tf_r <= task_file_i;
      end
   end

   // Completion pulse and status
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         irq_r <= 1'b0;
         res_r <= '0;
      end else begin
         irq_r <= exec;
         if (exec) begin
            res_r.abort     <= cmd_abort;
            res_r.ret_valid <= f_cur;
            res_r.ret_lo    <= f_cur ? CUR_LIMIT_MIN : tf_r.cyl_lo;
            res_r.ret_hi    <= f_cur ? CUR_LIMIT_MAX : tf_r.cyl_hi;
         end
      end
   end

   // Read native max must come immediately before; any other command breaks it
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || any_reset) begin
         prev_native_r <= 1'b0;
      end else if (read_native_ok_i) begin
         prev_native_r <= 1'b1;
      end else if (exec) begin
         prev_native_r <= 1'b0;
      end
   end

   // Power settings; the level is only stored, nothing consumes it
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || restore_def) begin
         apm_en_r    <= 1'b0;
         apm_level_r <= APM_LEVEL_DEF;
         stby_ok_r   <= 1'b0;
         pl1_en_r    <= 1'b0;
         cur_limit_r <= CUR_LIMIT_MAX;
      end else if (exec) begin
         if (f_apm_on && apm_valid) begin
            apm_en_r    <= 1'b1;
            apm_level_r <= cnt;
            stby_ok_r   <= apm_stby;
         end
         if (f_apm_off) begin
            apm_en_r  <= 1'b0;
            stby_ok_r <= 1'b0;
         end
         if (f_pl1_on || f_pl1_off) begin
            pl1_en_r <= f_pl1_on;
         end
         if (f_cur) begin
            cur_limit_r <= cur_next;
         end
      end
   end

   // Soft-reset policy itself survives soft reset, else it could never be off
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || hw_reset_i) begin
         por_soft_r <= 1'b1;
      end else if (exec && (f_por_off || f_por_on)) begin
         por_soft_r <= f_por_on;
      end
   end

   // Maximum address; the kept copy stands in for non-volatile storage
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         max_lba_r  <= NATIVE_MAX_LBA;
         kept_lba_r <= NATIVE_MAX_LBA;
      end else if (hw_reset_i) begin
         max_lba_r <= kept_lba_r;
      end else if (exec && addr_go) begin
         max_lba_r <= new_lba;
         if (keep_across_reset_flag) begin
            kept_lba_r <= new_lba;
         end
      end
   end

   // Lock state; password contents travel with data and are not handled here
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || hw_reset_i) begin
         locked_r    <= 1'b0;
         frozen_r    <= 1'b0;
         kept_done_r <= 1'b0;
      end else if (exec && !max_abort) begin
         if (m_lock || m_ulock) begin
            locked_r <= m_lock;
         end
         if (m_frz) begin
            frozen_r <= 1'b1;
         end
         if (addr_go && keep_across_reset_flag) begin
            kept_done_r <= 1'b1;
         end
      end
   end

   // Multiple mode
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || restore_def) begin
         mult_en_r  <= 1'b0;
         mult_cnt_r <= 8'h00;
      end else if (exec && is_mult) begin
         mult_en_r  <= blk_ok;
         mult_cnt_r <= blk_ok ? cnt : 8'h00;
      end
   end

   assign busy_o              = busy_r;
   assign done_irq_o          = irq_r;
   assign result_o            = res_r;
   assign apm_enabled_o       = apm_en_r;
   assign apm_level_o         = apm_level_r;
   assign standby_allowed_o   = stby_ok_r;
   assign pl1_enabled_o       = pl1_en_r;
   assign current_limit_o     = cur_limit_r;
   assign por_on_soft_reset_o = por_soft_r;
   assign max_lba_o           = max_lba_r;
   assign kept_max_lba_o      = kept_lba_r;
   assign max_locked_o        = locked_r;
   assign max_frozen_o        = frozen_r;
   assign multiple_en_o       = mult_en_r;
   assign multiple_count_o    = mult_cnt_r;

   // Checks
   busy_cycle_a: assert property (
      take |=> busy_o ##1 (!busy_o && done_irq_o)
   ) else $error("busy or completion timing wrong");

   apm_reserved_a: assert property (
      exec && f_apm_on && (cnt == APM_RSV_LO || cnt == APM_RSV_HI)
      |=> result_o.abort && $stable(apm_level_o)
   ) else $error("reserved level not aborted");

   apm_standby_a: assert property (
      apm_enabled_o && (apm_level_o >= APM_MIN_NOSTBY) |-> !standby_allowed_o
   ) else $error("standby allowed at high level");

   cur_range_a: assert property (
      exec && f_cur |=> result_o.ret_valid && !result_o.abort &&
      (result_o.ret_lo == CUR_LIMIT_MIN) && (result_o.ret_hi == CUR_LIMIT_MAX)
   ) else $error("current range not returned");

   cur_clamp_a: assert property (
      exec && f_cur && (cnt > CUR_LIMIT_MAX) |=> current_limit_o == CUR_LIMIT_MAX
   ) else $error("current limit not clamped");

   power_on_def_a: assert property (
      $past(reset_i) |-> !pl1_enabled_o && !multiple_en_o &&
      (current_limit_o == CUR_LIMIT_MAX) && por_on_soft_reset_o
   ) else $error("power-on defaults wrong");

   mult_zero_a: assert property (
      exec && is_mult && (cnt == 8'h00) |=> !multiple_en_o && !result_o.abort
   ) else $error("zero block count mishandled");

   mult_bad_a: assert property (
      exec && is_mult && (cnt > MULT_MAX) |=> result_o.abort && !multiple_en_o
   ) else $error("bad block count accepted");

   setmax_prereq_a: assert property (
      exec && m_addr && !prev_native_r |=> result_o.abort && $stable(max_lba_o)
   ) else $error("set max without read native");

   setmax_kept_a: assert property (
      exec && m_addr && keep_across_reset_flag && kept_done_r |=> result_o.abort
   ) else $error("second kept set max accepted");

   sf_unknown_a: assert property (
      exec && is_sf && !sf_known |=> result_o.abort ##1 !done_irq_o
   ) else $error("unknown subcommand accepted");

   apm_set_c:  cover property (exec && f_apm_on && apm_valid);
   setmax_c:   cover property (exec && addr_go ##1 done_irq_o);
   mult_on_c:  cover property (exec && is_mult && blk_ok);
   cur_lim_c:  cover property (exec && f_cur && (cnt < CUR_LIMIT_MIN));

endmodule

// >>> rtl/block_count_check.sv
// Checks a sectors-per-block request against the supported set.
// Supported counts are powers of two up to the block size limit.
`timescale 1ns/1ps
module block_count_check (
   // Request
   input  wire logic [7:0] count_i,
   // Verdict
   output logic            zero_o,
   output logic            supported_o
);
   import ata_cfg_pkg::*;

   wire [7:0] count_less = count_i - 8'h01;
   wire       pow2       = ((count_i & count_less) == 8'h00);

   assign zero_o      = (count_i == 8'h00);
   assign supported_o = !zero_o && pow2 && (count_i <= MULT_MAX);

endmodule

// >>> verification/ata_host_model.sv
// Host side: writes the task file and strobes one command at a time.
// Assumes the handler takes a command on the edge after the strobe rises.
`timescale 1ns/1ps
module ata_host_model (
   // Clock
   input  wire logic         clk_sys_i,
   // Requests to the drive
   output logic              cmd_valid_o,
   output ata_cfg_pkg::task_file_t task_file_o,
   output logic              read_native_ok_o
);
   import ata_cfg_pkg::*;
   initial begin
      cmd_valid_o = 1'b0;
      task_file_o = '0;
      read_native_ok_o = 1'b0;
   end
   // Level or limit is loaded with the opcode, never after it
   task automatic send(input task_file_t tf, input logic nat);
      if (nat) begin
         @(posedge clk_sys_i);
         read_native_ok_o <= 1'b1;
         @(posedge clk_sys_i);
         read_native_ok_o <= 1'b0;
      end
      @(posedge clk_sys_i);
      cmd_valid_o <= 1'b1;
      task_file_o <= tf;
      @(posedge clk_sys_i);
      cmd_valid_o <= 1'b0;
   endtask
endmodule

// >>> verification/tb_ata_config_command_handler.sv
// Self-checking bench for the configuration command handler.
// Assumes one drive with select bit zero; ready and soft reset are driven here.
`timescale 1ns/1ps
module tb_ata_config_command_handler;
   import ata_cfg_pkg::*;
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic hw_reset_i = 1'b0;
   logic soft_reset_i = 1'b0;
   logic ready = 1'b1;
   logic cmd_valid, native_ok, busy, irq, apm_en, sby, pl1, por, lck, frz, men;
   logic [7:0] lvl, cur, mcnt;
   logic [LBA_W-1:0] max_lba, kept;
   task_file_t tf;
   cmd_result_t res;
   int bad_count = 0;
   int num_checks = 0;
   always #2.5 clk_sys_i = ~clk_sys_i;
   ata_host_model hst (.clk_sys_i(clk_sys_i), .cmd_valid_o(cmd_valid), .task_file_o(tf),
      .read_native_ok_o(native_ok));
   ata_config_command_handler uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .hw_reset_i(hw_reset_i), .soft_reset_i(soft_reset_i), .cmd_valid_i(cmd_valid),
      .task_file_i(tf), .drive_select_bit_i(1'b0), .drive_ready_i(ready),
      .read_native_ok_i(native_ok), .busy_o(busy), .done_irq_o(irq), .result_o(res),
      .apm_enabled_o(apm_en), .apm_level_o(lvl), .standby_allowed_o(sby),
      .pl1_enabled_o(pl1), .current_limit_o(cur), .por_on_soft_reset_o(por),
      .max_lba_o(max_lba), .kept_max_lba_o(kept), .max_locked_o(lck),
      .max_frozen_o(frz), .multiple_en_o(men), .multiple_count_o(mcnt));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [27:0] s, input logic [27:0] e);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   // Issue one command and judge its busy, completion timing and abort flag
   task automatic run(input logic [7:0] c, f, n, dh, input logic nat, ab);
      int k;
      logic b;
      hst.send({c, f, n, 8'h34, 8'h12, 8'hab, dh}, nat);
      k = 0;
      b = 1'b0;
      while (irq !== 1'b1 && k < 4) begin
         @(posedge clk_sys_i);
         k++;
         b = b | busy;
      end
      chk("latency", 28'(k), 28'd2);
      chk("busy", b, 1'b1);
      chk("abort", res.abort, ab);
   endtask
   // One-cycle pulse on a reset input, then let the outputs settle
   task automatic pulse(input logic hw);
      @(posedge clk_sys_i);
      if (hw) hw_reset_i <= 1'b1;
      else soft_reset_i <= 1'b1;
      @(posedge clk_sys_i);
      hw_reset_i <= 1'b0;
      soft_reset_i <= 1'b0;
      @(posedge clk_sys_i);
      @(posedge clk_sys_i);
   endtask
   task automatic apm_scn;
      run(OP_SET_FEATURES, FT_APM_ON, APM_MIN_NOSTBY, 8'h00, 0, 0);
      chk("apm_en", apm_en, 1'b1);
      chk("standby", sby, 1'b0);
      run(OP_SET_FEATURES, FT_APM_ON, 8'h7f, 8'h00, 0, 0);
      chk("standby", sby, 1'b1);
      run(OP_SET_FEATURES, FT_APM_ON, APM_RSV_HI, 8'h00, 0, 1);
      run(OP_SET_FEATURES, FT_APM_ON, APM_RSV_LO, 8'h00, 0, 1);
      chk("level", lvl, 8'h7f);
      run(OP_SET_FEATURES, FT_APM_OFF, 8'h00, 8'h00, 0, 0);
      chk("apm_en", apm_en, 1'b0);
   endtask
   task automatic cur_scn;
      run(OP_SET_FEATURES, FT_CUR_LIMIT, 8'h06, 8'h00, 0, 0);
      chk("cur", cur, CUR_LIMIT_MIN);
      chk("ret", {res.ret_valid, res.ret_lo, res.ret_hi}, 17'h1197d);
      run(OP_SET_FEATURES, FT_CUR_LIMIT, 8'hff, 8'h00, 0, 0);
      chk("cur", cur, CUR_LIMIT_MAX);
   endtask
   // A command for the other drive must leave no trace
   task automatic sel_scn;
      logic b;
      b = 1'b0;
      hst.send({OP_SET_FEATURES, FT_PL1_ON, 8'h00, 8'h34, 8'h12, 8'hab, 8'h10}, 1'b0);
      repeat (3) begin
         @(posedge clk_sys_i);
         b = b | busy | irq;
      end
      chk("ignored", {b, pl1}, 2'b00);
   endtask
   task automatic misc_scn;
      run(OP_SET_FEATURES, FT_PL1_ON, 8'h00, 8'h00, 0, 0);
      chk("pl1", pl1, 1'b1);
      run(OP_SET_FEATURES, FT_PL1_OFF, 8'h00, 8'h00, 0, 0);
      chk("pl1", pl1, 1'b0);
      run(OP_SET_FEATURES, FT_PL1_ON, 8'h00, 8'h00, 0, 0);
      pulse(1'b0);
      chk("pl1", pl1, 1'b0);
      run(OP_SET_FEATURES, FT_POR_OFF, 8'h00, 8'h00, 0, 0);
      chk("por", por, 1'b0);
      run(OP_SET_FEATURES, FT_PL1_ON, 8'h00, 8'h00, 0, 0);
      pulse(1'b0);
      chk("soft", {pl1, por}, 2'b10);
      run(OP_SET_FEATURES, FT_POR_ON, 8'h00, 8'h00, 0, 0);
      chk("por", por, 1'b1);
      run(OP_SET_FEATURES, FT_RLA_OFF, 8'h00, 8'h00, 0, 0);
      run(OP_SET_FEATURES, FT_LONG_4B, 8'h00, 8'h00, 0, 0);
      run(OP_SET_FEATURES, 8'h01, 8'h00, 8'h00, 0, 1);
      run(8'h91, 8'h00, 8'h00, 8'h00, 0, 1);
   endtask
   task automatic max_scn;
      run(OP_SET_MAX, SM_ADDRESS, 8'h01, 8'h45, 0, 1);
      ready <= 1'b0;
      run(OP_SET_MAX, SM_ADDRESS, 8'h01, 8'h45, 1, 1);
      ready <= 1'b1;
      run(OP_SET_MAX, SM_ADDRESS, 8'h01, 8'h05, 1, 1);
      run(OP_SET_MAX, SM_ADDRESS, 8'h01, 8'h45, 1, 0);
      chk("max", max_lba, 28'h5ab1234);
      run(OP_SET_MAX, SM_ADDRESS, 8'h00, 8'h43, 1, 0);
      chk("kept", kept, 28'h5ab1234);
      chk("max", max_lba, 28'h3ab1234);
      run(OP_SET_MAX, SM_ADDRESS, 8'h01, 8'h45, 1, 1);
      pulse(1'b1);
      chk("max", max_lba, 28'h5ab1234);
      chk("pl1", pl1, 1'b0);
      run(OP_SET_MAX, SM_LOCK, 8'h00, 8'h45, 0, 0);
      chk("locked", lck, 1'b1);
      run(OP_SET_MAX, SM_ADDRESS, 8'h00, 8'h43, 1, 1);
      run(OP_SET_MAX, SM_UNLOCK, 8'h00, 8'h45, 0, 0);
      chk("locked", lck, 1'b0);
      run(OP_SET_MAX, SM_PASSWORD, 8'h00, 8'h45, 0, 0);
      run(OP_SET_MAX, 8'h05, 8'h00, 8'h45, 0, 1);
      run(OP_SET_MAX, SM_FREEZE, 8'h00, 8'h45, 0, 0);
      chk("frozen", frz, 1'b1);
      run(OP_SET_MAX, SM_LOCK, 8'h00, 8'h45, 0, 1);
      chk("locked", lck, 1'b0);
   endtask
   task automatic mult_scn;
      run(OP_SET_MULTIPLE, 8'h00, 8'h08, 8'h00, 0, 0);
      chk("mult", {men, mcnt}, 9'h108);
      run(OP_SET_MULTIPLE, 8'h00, 8'h03, 8'h00, 0, 1);
      chk("mult", men, 1'b0);
      run(OP_SET_MULTIPLE, 8'h00, MULT_MAX, 8'h00, 0, 0);
      chk("mult", {men, mcnt}, 9'h110);
      run(OP_SET_MULTIPLE, 8'h00, 8'h20, 8'h00, 0, 1);
      chk("mult", men, 1'b0);
      run(OP_SET_MULTIPLE, 8'h00, MULT_MAX, 8'h00, 0, 0);
      run(OP_SET_MULTIPLE, 8'h00, 8'h00, 8'h00, 0, 0);
      chk("mult", {men, mcnt}, 9'h000);
   endtask
   initial begin
      repeat (10) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      chk("cur", cur, CUR_LIMIT_MAX);
      chk("level", lvl, APM_LEVEL_DEF);
      chk("pl1", pl1, 1'b0);
      chk("por", por, 1'b1);
      chk("mult", men, 1'b0);
      apm_scn();
      cur_scn();
      sel_scn();
      misc_scn();
      max_scn();
      mult_scn();
      stop_test();
   end
   // Whole run is under two hundred cycles; this leaves ample margin
   initial begin
      #20us;
      bad_count++;
      stop_test();
   end
endmodule
